/* design/qcor_regs.sv */
/*
 * Q-channel offset and full-scale trim register bank behind the serial control port.
 * Assumes the serial engine delivers one-cycle write pulses and that the
 * extended control mode pin is asynchronous to mclk.
 */
// Function
// RQ1 - The host writes zeros to offset bits 15:13 and full-scale bit 15, which are stored as zero.
// RQ2 - Offset sign 0 gives a positive offset equal to the 12-bit magnitude.
// RQ3 - Offset sign 1 gives a negative offset of the same magnitude.
// RQ4 - Offset bits 11:0 are an unsigned magnitude, 0 for none up to 4095 for the largest.
// RQ5 - After reset the offset magnitude is zero, so no offset is applied.
// RQ6 - Full-scale bits 14:0 are an unsigned magnitude from code 0 to code 32767.
// RQ7 - After reset the full-scale field holds the mid code with only bit 14 set.
// RQ8 - The mid full-scale code in extended control mode equals the nominal range used outside it.
// RQ9 - Each register keeps its last write, drives the trim logic and reads back its value.
`timescale 1ns/1ps
`default_nettype none

module qcor_regs
    import qcor_pkg::*;
(
    input wire logic mclk, // System clock, 100 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic scs_n_pin, // Serial chip select, active low.
    input wire logic sclk_pin, // Serial clock.
    input wire logic sdi_pin, // Serial data in.
    input wire logic extended_control_mode_pin, // High selects the register-driven full-scale code.
    output logic sdo, // Serial data out.
    output logic sdo_oe_n, // Low while sdo is driven.
    output qcor_pkg::qcor_trim_t q_trim, // Stored trim fields.
    output logic [12:0] q_offset_signed, // Applied offset, two's complement.
    output logic [14:0] q_fullscale_code // Applied full-scale code.
);
    import qcor_pkg::*;

    // ------------------------------------------------------------------
    // Serial port and register storage
    // ------------------------------------------------------------------
    qcor_wr_t wr;
    logic [3:0] rd_addr;
    logic [15:0] rd_data;
    logic [12:0] offset_r, offset_nxt;
    logic [14:0] fsr_r, fsr_nxt;
    logic [2:0] ecm_sync_r, ecm_sync_nxt;
    logic ecm_r, ecm_nxt;
    qcor_trim_t trim_r, trim_nxt;
    logic [12:0] ofs_out_r, ofs_out_nxt;
    logic [14:0] fsc_out_r, fsc_out_nxt;

    qcor_serial_port i_qcor_serial_port (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .scs_n_pin(scs_n_pin),
        .sclk_pin(sclk_pin),
        .sdi_pin(sdi_pin),
        .rd_data(rd_data),
        .rd_addr(rd_addr),
        .wr(wr),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n)
    );

    // True for a write pulse aimed at the given register address.
    function automatic logic hits_reg(input qcor_wr_t w, input logic [3:0] addr);
        hits_reg = w.wr && (w.addr == addr);
    endfunction : hits_reg

    // Writes keep only the field bits; reserved bits are never stored.
    always_comb begin
        offset_nxt = offset_r;
        fsr_nxt = fsr_r;
        if (hits_reg(wr, QCOR_ADDR_OFFSET)) begin
            offset_nxt = wr.data[QCOR_OFS_SIGN_POS:0]; // see RQ1 see RQ4 see RQ9
        end
        if (hits_reg(wr, QCOR_ADDR_FSR)) begin
            fsr_nxt = wr.data[QCOR_FSR_MSB:0]; // see RQ1 see RQ6 see RQ9
        end
    end

    // Read mux; reserved bits and unmapped addresses read as zero.
    always_comb begin
        unique case (rd_addr)
            QCOR_ADDR_OFFSET: rd_data = {3'h0, offset_r}; // see RQ9
            QCOR_ADDR_FSR: rd_data = {1'h0, fsr_r}; // see RQ9
            default: rd_data = QCOR_RD_UNMAPPED;
        endcase
    end

    // ------------------------------------------------------------------
    // Trim outputs
    // ------------------------------------------------------------------

    // Mode pin synchroniser and the registered trim values for the core.
    always_comb begin
        ecm_sync_nxt = {ecm_sync_r[1:0], extended_control_mode_pin};
        ecm_nxt = (ecm_sync_r[1] == ecm_sync_r[2]) ? ecm_sync_r[2] : ecm_r;
        trim_nxt.offset_sign_bit = offset_r[QCOR_OFS_SIGN_POS];
        trim_nxt.offset_magnitude = offset_r[QCOR_OFS_MAG_MSB:0];
        trim_nxt.fullscale_magnitude = fsr_r;
        ofs_out_nxt = qcor_signed_offset(offset_r[QCOR_OFS_SIGN_POS],
            offset_r[QCOR_OFS_MAG_MSB:0]); // see RQ2 see RQ3
        fsc_out_nxt = ecm_r ? fsr_r : QCOR_FSR_MID; // see RQ8
    end

    // Register stage with reset values of the trim fields.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            offset_r <= QCOR_RST_OFFSET[QCOR_OFS_SIGN_POS:0]; // see RQ5
            fsr_r <= QCOR_RST_FSR[QCOR_FSR_MSB:0]; // see RQ7
            ecm_sync_r <= '0;
            ecm_r <= 1'b0;
            trim_r <= {QCOR_RST_OFFSET[QCOR_OFS_SIGN_POS:0], QCOR_RST_FSR[QCOR_FSR_MSB:0]}; // see RQ7
            ofs_out_r <= '0;
            fsc_out_r <= QCOR_FSR_MID;
        end else begin
            offset_r <= offset_nxt;
            fsr_r <= fsr_nxt;
            ecm_sync_r <= ecm_sync_nxt;
            ecm_r <= ecm_nxt;
            trim_r <= trim_nxt;
            ofs_out_r <= ofs_out_nxt;
            fsc_out_r <= fsc_out_nxt;
        end
    end

    assign q_trim = trim_r;
    assign q_offset_signed = ofs_out_r;
    assign q_fullscale_code = fsc_out_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // A positive sign yields the magnitude unchanged.
    property p_pos_offset;
        !q_trim.offset_sign_bit |-> q_offset_signed == {1'b0, q_trim.offset_magnitude};
    endproperty
    a_pos_offset: assert property (p_pos_offset) else $error("positive offset wrong"); // see RQ2

    // A negative sign yields the negated magnitude.
    property p_neg_offset;
        q_trim.offset_sign_bit |-> q_offset_signed + {1'b0, q_trim.offset_magnitude} == 13'h0000;
    endproperty
    a_neg_offset: assert property (p_neg_offset) else $error("negative offset wrong"); // see RQ3

    // An offset write reaches the trim outputs two cycles later.
    property p_ofs_write;
        hits_reg(wr, QCOR_ADDR_OFFSET)
            |-> ##2 q_trim.offset_magnitude == $past(wr.data[QCOR_OFS_MAG_MSB:0], 2);
    endproperty
    a_ofs_write: assert property (p_ofs_write) else $error("offset write lost"); // see RQ4

    // Leaving reset the offset is zero.
    property p_ofs_reset;
        $past(sys_rst) |-> offset_r == QCOR_RST_OFFSET[QCOR_OFS_SIGN_POS:0];
    endproperty
    a_ofs_reset: assert property (p_ofs_reset) else $error("offset reset wrong"); // see RQ5

    // A full-scale write is stored in the next cycle, top bit dropped.
    property p_fsr_write;
        wr.wr && wr.addr == QCOR_ADDR_FSR |=> fsr_r == $past(wr.data[QCOR_FSR_MSB:0]);
    endproperty
    a_fsr_write: assert property (p_fsr_write) else $error("full-scale write lost"); // see RQ6

    // Leaving reset the full-scale field holds the mid code.
    property p_fsr_reset;
        $past(sys_rst) |-> fsr_r == QCOR_RST_FSR[QCOR_FSR_MSB:0];
    endproperty
    a_fsr_reset: assert property (p_fsr_reset) else $error("full-scale reset wrong"); // see RQ7

    // A full-scale write reaches the trim outputs two cycles later.
    property p_fsr_trim;
        hits_reg(wr, QCOR_ADDR_FSR)
            |-> ##2 q_trim.fullscale_magnitude == $past(wr.data[QCOR_FSR_MSB:0], 2);
    endproperty
    a_fsr_trim: assert property (p_fsr_trim) else $error("full-scale trim lost"); // see RQ6

    // Leaving reset the applied offset is zero, so the core sees no offset.
    property p_out_reset;
        $past(sys_rst) |-> q_offset_signed == '0 && q_trim.offset_magnitude == '0;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("offset output reset wrong"); // see RQ5

    // Leaving reset the core already sees the mid full-scale code.
    property p_fsc_reset;
        $past(sys_rst) |-> q_trim.fullscale_magnitude == QCOR_RST_FSR[QCOR_FSR_MSB:0]
            && q_fullscale_code == QCOR_FSR_MID;
    endproperty
    a_fsc_reset: assert property (p_fsc_reset) else $error("full-scale output reset wrong"); // see RQ7

    // Outside extended mode the applied code is the nominal mid code.
    property p_nominal;
        !ecm_r |=> q_fullscale_code == QCOR_FSR_MID;
    endproperty
    a_nominal: assert property (p_nominal) else $error("nominal range not applied"); // see RQ8

    // In extended mode the applied code follows the register.
    property p_ext_mode;
        ecm_r |=> q_fullscale_code == $past(fsr_r);
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("register range not applied"); // see RQ8

    // Without a write both registers hold their value.
    property p_hold;
        !wr.wr |=> $stable(offset_r) && $stable(fsr_r);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write"); // see RQ9

    // The read mux returns the stored offset with zero reserved bits.
    property p_readback;
        rd_addr == QCOR_ADDR_OFFSET |-> rd_data == {3'h0, offset_r};
    endproperty
    a_readback: assert property (p_readback) else $error("offset readback wrong"); // see RQ9

    // Main scenarios.
    c_ofs_write: cover property (wr.wr && wr.addr == QCOR_ADDR_OFFSET);
    c_fsr_write: cover property (wr.wr && wr.addr == QCOR_ADDR_FSR);
    c_negative: cover property (q_trim.offset_sign_bit && q_trim.offset_magnitude != '0);
    c_read: cover property ($fell(sdo_oe_n));
    c_ext_mode: cover property (ecm_r && fsr_r != QCOR_FSR_MID);

endmodule : qcor_regs

`default_nettype wire

/* inc/qcor_pkg.sv */
/*
 * Shared constants, carrier types and helpers for the Q-channel trim register bank.
 * Assumes one 100 MHz clock with a synchronous active-high reset. The serial
 * control pins are asynchronous to that clock.
 */
package qcor_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] QCOR_ADDR_OFFSET = 4'ha;
    localparam logic [3:0] QCOR_ADDR_FSR = 4'hb;
    localparam logic [15:0] QCOR_RST_OFFSET = 16'h0000;
    localparam logic [15:0] QCOR_RST_FSR = 16'h4000;
    localparam logic [15:0] QCOR_RD_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int QCOR_OFS_SIGN_POS = 12;
    localparam int QCOR_OFS_MAG_MSB = 11;
    localparam int QCOR_FSR_MSB = 14;
    localparam logic [14:0] QCOR_FSR_MID = 15'h4000;

    // ------------------------------------------------------------------
    // Serial frame: 8 header bits (bit 7 set for a read, bits 3:0 address),
    // then 16 data bits, most significant bit first.
    // ------------------------------------------------------------------
    localparam int QCOR_HDR_RW_POS = 7;
    localparam logic [3:0] QCOR_HDR_LAST = 4'h7;
    localparam logic [3:0] QCOR_DATA_LAST = 4'hf;
    localparam int QCOR_PIN_CS = 0;
    localparam int QCOR_PIN_SCLK = 1;
    localparam int QCOR_PIN_SDI = 2;

    // Serial engine states.
    typedef enum logic [2:0] {
        QCOR_ST_IDLE = 3'b000,
        QCOR_ST_HEADER = 3'b001,
        QCOR_ST_LOAD = 3'b010,
        QCOR_ST_DATA = 3'b011,
        QCOR_ST_DONE = 3'b100
    } qcor_state_t;

    // Trim settings presented to the converter core.
    typedef struct packed {
        logic offset_sign_bit;
        logic [11:0] offset_magnitude;
        logic [14:0] fullscale_magnitude;
    } qcor_trim_t;

    // One register write taken from the serial port.
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [15:0] data;
    } qcor_wr_t;

    // Turns sign and magnitude into a two's complement offset code.
    function automatic logic [12:0] qcor_signed_offset(input logic sign, input logic [11:0] mag);
        logic [12:0] ext;
        ext = {1'b0, mag};
        qcor_signed_offset = sign ? 13'(-ext) : ext;
    endfunction : qcor_signed_offset

endpackage : qcor_pkg

/* design/qcor_serial_port.sv */
/*
 * Serial control port engine: synchronises the pins, frames header and data,
 * issues one write pulse per write frame and shifts read data out.
 * Assumes the serial clock half period spans at least four mclk cycles and
 * that chip select falls at least four mclk cycles before the first clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module qcor_serial_port
    import qcor_pkg::*;
(
    input wire logic mclk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic scs_n_pin, // Chip select pin, active low.
    input wire logic sclk_pin, // Serial clock pin.
    input wire logic sdi_pin, // Serial data in pin.
    input wire logic [15:0] rd_data, // Read data for rd_addr.
    output logic [3:0] rd_addr, // Address of the frame under way.
    output qcor_pkg::qcor_wr_t wr, // One-cycle write pulse with address and data.
    output logic sdo, // Serial data out.
    output logic sdo_oe_n // Output enable for sdo, low while driving.
);
    import qcor_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt, st_r, st_nxt;
    logic sclk_prev_r, sclk_prev_nxt;
    qcor_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt, tx_r, tx_nxt;
    logic rw_r, rw_nxt, sdo_r, sdo_nxt, oe_n_r, oe_n_nxt;
    qcor_wr_t wr_r, wr_nxt;
    logic [3:0] rd_addr_r, rd_addr_nxt;
    logic rise, fall, cs_act;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Three-stage pin synchroniser; a level counts once stages two and three agree.
    always_comb begin
        s1_nxt = {sdi_pin, sclk_pin, scs_n_pin};
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        st_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & st_r);
        sclk_prev_nxt = st_r[QCOR_PIN_SCLK];
    end

    assign rise = st_r[QCOR_PIN_SCLK] & ~sclk_prev_r;
    assign fall = ~st_r[QCOR_PIN_SCLK] & sclk_prev_r;
    assign cs_act = ~st_r[QCOR_PIN_CS];

    // Frame sequencer: header, one cycle to fetch read data, then data bits.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        rw_nxt = rw_r;
        sdo_nxt = sdo_r;
        oe_n_nxt = oe_n_r;
        rd_addr_nxt = rd_addr_r;
        wr_nxt = '0;
        if (!cs_act) begin
            state_nxt = QCOR_ST_IDLE;
            cnt_nxt = '0;
            oe_n_nxt = 1'b1;
        end else begin
            unique case (state_r)
                QCOR_ST_IDLE: begin
                    state_nxt = QCOR_ST_HEADER;
                    cnt_nxt = '0;
                end
                QCOR_ST_HEADER: begin
                    if (rise) begin
                        sh_nxt = {sh_r[14:0], st_r[QCOR_PIN_SDI]};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == QCOR_HDR_LAST) begin
                            state_nxt = QCOR_ST_LOAD;
                            rd_addr_nxt = {sh_r[2:0], st_r[QCOR_PIN_SDI]}; // Last header bit.
                        end
                    end
                end
                QCOR_ST_LOAD: begin
                    rw_nxt = sh_r[QCOR_HDR_RW_POS];
                    tx_nxt = rd_data;
                    cnt_nxt = '0;
                    state_nxt = QCOR_ST_DATA;
                end
                QCOR_ST_DATA: begin
                    if (fall && rw_r) begin
                        sdo_nxt = tx_r[15];
                        tx_nxt = {tx_r[14:0], 1'b0};
                        oe_n_nxt = 1'b0;
                    end
                    if (rise) begin
                        sh_nxt = {sh_r[14:0], st_r[QCOR_PIN_SDI]};
                        cnt_nxt = cnt_r + 4'h1;
                        if (cnt_r == QCOR_DATA_LAST) begin
                            state_nxt = QCOR_ST_DONE;
                            wr_nxt.wr = ~rw_r;
                            wr_nxt.addr = rd_addr_r;
                            wr_nxt.data = {sh_r[14:0], st_r[QCOR_PIN_SDI]};
                        end
                    end
                end
                QCOR_ST_DONE: begin
                    state_nxt = QCOR_ST_DONE;
                end
                default: begin
                    state_nxt = QCOR_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // All state is registered here with a synchronous reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_r <= 3'h3;
            s2_r <= 3'h3;
            s3_r <= 3'h3;
            st_r <= 3'h3;
            sclk_prev_r <= 1'b1;
            state_r <= QCOR_ST_IDLE;
            cnt_r <= '0;
            sh_r <= '0;
            tx_r <= '0;
            rw_r <= 1'b0;
            sdo_r <= 1'b0;
            oe_n_r <= 1'b1;
            wr_r <= '0;
            rd_addr_r <= '0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            st_r <= st_nxt;
            sclk_prev_r <= sclk_prev_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            rw_r <= rw_nxt;
            sdo_r <= sdo_nxt;
            oe_n_r <= oe_n_nxt;
            wr_r <= wr_nxt;
            rd_addr_r <= rd_addr_nxt;
        end
    end

    assign wr = wr_r;
    assign rd_addr = rd_addr_r;
    assign sdo = sdo_r;
    assign sdo_oe_n = oe_n_r;

endmodule : qcor_serial_port

`default_nettype wire

/* dv/qcor_regs_tb.sv */
/*
 * Self-checking testbench for the Q-channel trim register bank.
 * Assumes the serial frame of the design package and a 100 MHz mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module qcor_regs_tb;
    import qcor_pkg::*;

    logic mclk;
    logic sys_rst;
    logic scs_n_pin;
    logic sclk_pin;
    logic sdi_pin;
    logic ext_mode;
    logic sdo;
    logic sdo_oe_n;
    qcor_trim_t q_trim;
    logic [12:0] q_offset_signed;
    logic [14:0] q_fullscale_code;
    logic [15:0] rv;
    int num_errors;
    int cmp_count;

    // ------------------------------------------------------------------
    // Clock, device and common tasks
    // ------------------------------------------------------------------
    // The clock toggles every half period of 5 ns.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    qcor_regs i_qcor_regs (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .scs_n_pin(scs_n_pin),
        .sclk_pin(sclk_pin),
        .sdi_pin(sdi_pin),
        .extended_control_mode_pin(ext_mode),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n),
        .q_trim(q_trim),
        .q_offset_signed(q_offset_signed),
        .q_fullscale_code(q_fullscale_code)
    );

    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Holds reset for 20 cycles with the pins idle, then lets it settle.
    task automatic do_reset();
        @(negedge mclk);
        sys_rst = 1'b1;
        scs_n_pin = 1'b1;
        sclk_pin = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (6) @(negedge mclk);
    endtask : do_reset

    // Sends one frame of nbits bits, MSB first, sampling sdo on rising sclk.
    task automatic frame(input logic rd, input logic [3:0] addr, input logic [15:0] data,
                         input int nbits, output logic [15:0] rdval);
        logic [23:0] word;
        word = {rd, 3'h0, addr, data};
        rdval = 16'h0000;
        scs_n_pin = 1'b0;
        repeat (6) @(negedge mclk);
        for (int i = 0; i < nbits; i++) begin
            sclk_pin = 1'b0;
            sdi_pin = word[23-i];
            repeat (8) @(negedge mclk);
            if (i >= 8) begin
                rdval[23-i] = sdo;
            end
            if (rd && i == 8) begin
                check({31'h0, sdo_oe_n}, 32'h0);
            end
            sclk_pin = 1'b1;
            repeat (8) @(negedge mclk);
        end
        // Idle level differs from the last bit so a stale sample shows up.
        sdi_pin = ~sdi_pin;
        scs_n_pin = 1'b1;
        repeat (12) @(negedge mclk);
    endtask : frame

    // Host writes keep the unused upper bits at zero.
    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        logic [15:0] dummy;
        frame(1'b0, addr, data, 24, dummy);
    endtask : wr

    // Compares the trim outputs with the stored fields and the mode pin.
    task automatic check_out(input logic sign, input logic [11:0] mag, input logic [14:0] fsr);
        logic [12:0] eofs;
        logic [14:0] efsr;
        eofs = sign ? 13'h0 - {1'b0, mag} : {1'b0, mag};
        efsr = ext_mode ? fsr : 15'h4000;
        check({4'h0, q_trim}, {4'h0, sign, mag, fsr});
        check({19'h0, q_offset_signed}, {19'h0, eofs});
        check({17'h0, q_fullscale_code}, {17'h0, efsr});
    endtask : check_out

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values read back and reach the trim outputs.
    task automatic test_reset_values();
        frame(1'b1, 4'ha, 16'h0000, 24, rv);
        check({16'h0, rv}, 32'h0000);
        frame(1'b1, 4'hb, 16'h0000, 24, rv);
        check({16'h0, rv}, 32'h4000);
        check_out(1'b0, 12'h000, 15'h4000);
    endtask : test_reset_values

    // Offset sign and magnitude at their boundary codes.
    task automatic test_offset();
        logic [15:0] codes [4];
        codes = '{16'h0fff, 16'h1005, 16'h1fff, 16'h1000};
        foreach (codes[k]) begin
            wr(4'ha, codes[k]);
            check_out(codes[k][12], codes[k][11:0], 15'h4000);
            frame(1'b1, 4'ha, 16'h0000, 24, rv);
            check({16'h0, rv}, {16'h0, codes[k]});
        end
    endtask : test_offset

    // Full-scale code applied only in extended mode; mid code matches nominal.
    task automatic test_fullscale();
        logic [15:0] codes [3];
        codes = '{16'h7fff, 16'h0000, 16'h4000};
        ext_mode = 1'b1;
        repeat (10) @(negedge mclk);
        foreach (codes[k]) begin
            wr(4'hb, codes[k]);
            check_out(1'b1, 12'h000, codes[k][14:0]);
            frame(1'b1, 4'hb, 16'h0000, 24, rv);
            check({16'h0, rv}, {16'h0, codes[k]});
        end
        wr(4'hb, 16'h2abc);
        ext_mode = 1'b0;
        repeat (10) @(negedge mclk);
        check_out(1'b1, 12'h000, 15'h2abc);
        ext_mode = 1'b1;
        repeat (10) @(negedge mclk);
        check_out(1'b1, 12'h000, 15'h2abc);
    endtask : test_fullscale

    // Unmapped accesses and an aborted frame leave the registers alone.
    task automatic test_unmapped_abort();
        wr(4'h3, 16'h1234);
        frame(1'b1, 4'h3, 16'h0000, 24, rv);
        check({16'h0, rv}, 32'h0000);
        frame(1'b0, 4'ha, 16'h0abc, 14, rv);
        check_out(1'b1, 12'h000, 15'h2abc);
        frame(1'b1, 4'ha, 16'h0000, 24, rv);
        check({16'h0, rv}, 32'h1000);
    endtask : test_unmapped_abort

    // A second reset in mid-run restores both registers.
    task automatic test_second_reset();
        wr(4'ha, 16'h1800);
        do_reset();
        check_out(1'b0, 12'h000, 15'h4000);
        frame(1'b1, 4'hb, 16'h0000, 24, rv);
        check({16'h0, rv}, 32'h4000);
    endtask : test_second_reset

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    // The tests need about 9200 cycles; the limit is far above that.
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end

    // Drives every input at time zero, then runs the scenarios.
    initial begin
        num_errors = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        scs_n_pin = 1'b1;
        sclk_pin = 1'b1;
        sdi_pin = 1'b0;
        ext_mode = 1'b0;
        do_reset();
        test_reset_values();
        test_offset();
        test_fullscale();
        test_unmapped_abort();
        test_second_reset();
        give_verdict();
    end

endmodule : qcor_regs_tb

`default_nettype wire
